/* rtl/irq_consts.vh */
`ifndef IRQ_CONSTS_VH
`define IRQ_CONSTS_VH

// special function register addresses
`define ADDR_TIMER_IRQ_CONTROL   8'h88
`define ADDR_IRQ_ENABLE          8'hA8
`define ADDR_PRIORITY_LOW_BITS   8'hA9
`define ADDR_PRIORITY_HIGH_BITS  8'hAA
`define ADDR_EXT_EDGE_SELECT     8'hAB

// reset values
`define RST_TIMER_IRQ_CONTROL    8'h00
`define RST_IRQ_ENABLE           8'h00
`define RST_PRIORITY             7'h00
`define RST_EXT_EDGE_SELECT      4'h5

// timer_irq_control fields
`define BIT_EXT0_EDGE_MODE       0
`define BIT_EXT0_REQUEST_FLAG    1
`define BIT_EXT1_EDGE_MODE       2
`define BIT_EXT1_REQUEST_FLAG    3
`define BIT_TIMER0_RUN           4
`define BIT_TIMER0_OVERFLOW_FLAG 5
`define BIT_TIMER1_RUN           6
`define BIT_TIMER1_OVERFLOW_FLAG 7

// irq_enable fields
`define BIT_EXT0_IRQ_ENABLE      0
`define BIT_TIMER0_IRQ_ENABLE    1
`define BIT_EXT1_IRQ_ENABLE      2
`define BIT_TIMER1_IRQ_ENABLE    3
`define BIT_UART_IRQ_ENABLE      4
`define BIT_I2C_IRQ_ENABLE       5
`define BIT_ADC_IRQ_ENABLE       6
`define BIT_GLOBAL_IRQ_ENABLE    7

// ext_edge_select_reg fields
`define BIT_EXT0_FALLING_ENABLE  0
`define BIT_EXT0_RISING_ENABLE   1
`define BIT_EXT1_FALLING_ENABLE  2
`define BIT_EXT1_RISING_ENABLE   3

// source indices, also the polling order within one level
`define SRC_EXT0                 0
`define SRC_TIMER0               1
`define SRC_EXT1                 2
`define SRC_TIMER1               3
`define SRC_UART                 4
`define SRC_I2C                  5
`define SRC_ADC                  6
`define NUM_SRC                  7

// service routine start addresses
`define VEC_EXT0                 8'h03
`define VEC_TIMER0               8'h0B
`define VEC_EXT1                 8'h13
`define VEC_TIMER1               8'h1B
`define VEC_UART                 8'h23
`define VEC_I2C                  8'h2B
`define VEC_ADC                  8'h33

`endif

/* rtl/ext_pin_filter.v */
`timescale 1ns/1ps
`default_nettype none

// three-stage synchroniser; a change counts once stages two and three agree
module ext_pin_filter (
  input  wire core_clk,
  input  wire rstn,
  input  wire pin,
  output reg  level,
  output reg  rise,
  output reg  fall
);

  reg s1;
  reg s2;
  reg s3;

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s1    <= 1'b1;
      s2    <= 1'b1;
      s3    <= 1'b1;
      level <= 1'b1;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end else begin
      s1   <= pin;
      s2   <= s1;
      s3   <= s2;
      rise <= 1'b0;
      fall <= 1'b0;
      if (s2 == s3 && s3 != level) begin
        level <= s3;
        rise  <= s3;
        fall  <= ~s3;
      end
    end
  end

endmodule // ext_pin_filter

`default_nettype wire

/* rtl/priority_interrupt_controller.v */
`timescale 1ns/1ps
`default_nettype none
`include "irq_consts.vh"

module priority_interrupt_controller (
  input  wire       core_clk,
  input  wire       rstn,
  // special function register port of the core
  input  wire [7:0] sfr_addr,
  input  wire [7:0] sfr_wdata,
  input  wire       sfr_wr,
  input  wire       sfr_rd,
  output reg  [7:0] sfr_rdata,
  output wire       sfr_hit,
  // request sources
  input  wire       ext_request0_pin,
  input  wire       ext_request1_pin,
  input  wire       timer0_overflow,
  input  wire       timer1_overflow,
  input  wire       uart_rx_flag,
  input  wire       uart_tx_done_flag,
  input  wire       i2c_request_flag,
  input  wire       adc_high_limit_flag,
  input  wire       adc_low_limit_flag,
  output wire       timer0_run,
  output wire       timer1_run,
  // core handshake
  output reg        irq_req,
  output reg  [7:0] irq_vector,
  output reg  [1:0] irq_level,
  input  wire       irq_ack,
  input  wire       return_from_irq,
  output reg  [3:0] active_levels
);

  reg  [7:0] irq_enable;
  reg  [6:0] priority_low_bits;
  reg  [6:0] priority_high_bits;
  reg  [3:0] ext_edge_select_reg;
  reg        ext0_edge_mode;
  reg        ext1_edge_mode;
  reg  [1:0] ext_request_flag;
  reg        timer0_overflow_flag;
  reg        timer1_overflow_flag;
  reg        timer0_run_bit;
  reg        timer1_run_bit;
  reg  [6:0] req_src;

  wire [1:0] pin_level;
  wire [1:0] pin_rise;
  wire [1:0] pin_fall;
  wire [1:0] edge_mode;
  wire [1:0] rise_en;
  wire [1:0] fall_en;
  wire [1:0] ext_ack;
  wire [1:0] ext_sw_wr;
  wire [1:0] ext_sw_val;
  wire [6:0] flags;
  wire [6:0] pending;
  wire       wr_timer_irq_control;
  wire       wr_ie;
  wire       wr_ip0;
  wire       wr_ip1;
  wire       wr_irc;

  // level of one source from the two priority registers
  function [1:0] level_of;
    input [6:0] hi;
    input [6:0] lo;
    input [2:0] idx;
    begin
      level_of = {hi[idx], lo[idx]};
    end
  endfunction

  // highest set active-level flip-flop, and whether any is set
  function [2:0] top_active;
    input [3:0] act;
    begin
      if (act[3]) begin
        top_active = 3'b111;
      end else if (act[2]) begin
        top_active = 3'b110;
      end else if (act[1]) begin
        top_active = 3'b101;
      end else if (act[0]) begin
        top_active = 3'b100;
      end else begin
        top_active = 3'b000;
      end
    end
  endfunction

  function [7:0] vector_of;
    input [2:0] idx;
    begin
      case (idx)
        3'd`SRC_EXT0:   vector_of = `VEC_EXT0;
        3'd`SRC_TIMER0: vector_of = `VEC_TIMER0;
        3'd`SRC_EXT1:   vector_of = `VEC_EXT1;
        3'd`SRC_TIMER1: vector_of = `VEC_TIMER1;
        3'd`SRC_UART:   vector_of = `VEC_UART;
        3'd`SRC_I2C:    vector_of = `VEC_I2C;
        default:        vector_of = `VEC_ADC;
      endcase
    end
  endfunction

  function reg_hit;
    input [7:0] a;
    begin
      if (a == `ADDR_TIMER_IRQ_CONTROL) begin
        reg_hit = 1'b1;
      end else if (a == `ADDR_IRQ_ENABLE) begin
        reg_hit = 1'b1;
      end else if (a == `ADDR_PRIORITY_LOW_BITS) begin
        reg_hit = 1'b1;
      end else if (a == `ADDR_PRIORITY_HIGH_BITS) begin
        reg_hit = 1'b1;
      end else if (a == `ADDR_EXT_EDGE_SELECT) begin
        reg_hit = 1'b1;
      end else begin
        reg_hit = 1'b0;
      end
    end
  endfunction

  assign sfr_hit = reg_hit(sfr_addr);
  assign wr_timer_irq_control = sfr_wr && (sfr_addr == `ADDR_TIMER_IRQ_CONTROL);
  assign wr_ie   = sfr_wr && (sfr_addr == `ADDR_IRQ_ENABLE);
  assign wr_ip0  = sfr_wr && (sfr_addr == `ADDR_PRIORITY_LOW_BITS);
  assign wr_ip1  = sfr_wr && (sfr_addr == `ADDR_PRIORITY_HIGH_BITS);
  assign wr_irc  = sfr_wr && (sfr_addr == `ADDR_EXT_EDGE_SELECT);

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_enable          <= `RST_IRQ_ENABLE;
      priority_low_bits   <= `RST_PRIORITY;
      priority_high_bits  <= `RST_PRIORITY;
      ext_edge_select_reg <= `RST_EXT_EDGE_SELECT;
      ext0_edge_mode      <= 1'b0;
      ext1_edge_mode      <= 1'b0;
      timer0_run_bit      <= 1'b0;
      timer1_run_bit      <= 1'b0;
    end else begin
      if (wr_ie) begin
        irq_enable <= sfr_wdata;
      end
      if (wr_ip0) begin
        priority_low_bits <= sfr_wdata[6:0];
      end
      if (wr_ip1) begin
        priority_high_bits <= sfr_wdata[6:0];
      end
      if (wr_irc) begin
        ext_edge_select_reg <= sfr_wdata[3:0];
      end
      if (wr_timer_irq_control) begin
        ext0_edge_mode <= sfr_wdata[`BIT_EXT0_EDGE_MODE];
        ext1_edge_mode <= sfr_wdata[`BIT_EXT1_EDGE_MODE];
        timer0_run_bit <= sfr_wdata[`BIT_TIMER0_RUN];
        timer1_run_bit <= sfr_wdata[`BIT_TIMER1_RUN];
      end
    end
  end

  assign timer0_run = timer0_run_bit;
  assign timer1_run = timer1_run_bit;

  // read data registered; unmapped addresses read zero
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      if (sfr_addr == `ADDR_TIMER_IRQ_CONTROL) begin
        sfr_rdata <= {timer1_overflow_flag, timer1_run_bit,
                      timer0_overflow_flag, timer0_run_bit,
                      ext_request_flag[1], ext1_edge_mode,
                      ext_request_flag[0], ext0_edge_mode};
      end else if (sfr_addr == `ADDR_IRQ_ENABLE) begin
        sfr_rdata <= irq_enable;
      end else if (sfr_addr == `ADDR_PRIORITY_LOW_BITS) begin
        sfr_rdata <= {1'b0, priority_low_bits};
      end else if (sfr_addr == `ADDR_PRIORITY_HIGH_BITS) begin
        sfr_rdata <= {1'b0, priority_high_bits};
      end else if (sfr_addr == `ADDR_EXT_EDGE_SELECT) begin
        sfr_rdata <= {4'h0, ext_edge_select_reg};
      end else begin
        sfr_rdata <= 8'h00;
      end
    end
  end

  assign edge_mode  = {ext1_edge_mode, ext0_edge_mode};
  assign rise_en    = {ext_edge_select_reg[`BIT_EXT1_RISING_ENABLE],
                       ext_edge_select_reg[`BIT_EXT0_RISING_ENABLE]};
  assign fall_en    = {ext_edge_select_reg[`BIT_EXT1_FALLING_ENABLE],
                       ext_edge_select_reg[`BIT_EXT0_FALLING_ENABLE]};
  assign ext_ack    = {irq_ack & irq_req & req_src[`SRC_EXT1],
                       irq_ack & irq_req & req_src[`SRC_EXT0]};
  assign ext_sw_val = {sfr_wdata[`BIT_EXT1_REQUEST_FLAG],
                       sfr_wdata[`BIT_EXT0_REQUEST_FLAG]};
  assign ext_sw_wr  = {wr_timer_irq_control, wr_timer_irq_control};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : ext_in
      wire pin_in = (g == 0) ? ext_request0_pin : ext_request1_pin;

      ext_pin_filter u_filter (
        .core_clk (core_clk),
        .rstn     (rstn),
        .pin      (pin_in),
        .level    (pin_level[g]),
        .rise     (pin_rise[g]),
        .fall     (pin_fall[g])
      );

      always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          ext_request_flag[g] <= 1'b0;
        end else if (!edge_mode[g]) begin
          // level mode: flag follows the inverted sampled pin
          ext_request_flag[g] <= ~pin_level[g];
        end else if ((pin_rise[g] & rise_en[g]) |
                     (pin_fall[g] & fall_en[g])) begin
          // an edge wins over a same-cycle clear
          ext_request_flag[g] <= 1'b1;
        end else if (ext_ack[g]) begin
          ext_request_flag[g] <= 1'b0;
        end else if (ext_sw_wr[g]) begin
          ext_request_flag[g] <= ext_sw_val[g];
        end
      end
    end
  endgenerate

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      timer0_overflow_flag <= 1'b0;
      timer1_overflow_flag <= 1'b0;
    end else begin
      if (timer0_overflow) begin
        timer0_overflow_flag <= 1'b1;
      end else if (irq_ack && irq_req && req_src[`SRC_TIMER0]) begin
        timer0_overflow_flag <= 1'b0;
      end else if (wr_timer_irq_control) begin
        timer0_overflow_flag <= sfr_wdata[`BIT_TIMER0_OVERFLOW_FLAG];
      end
      if (timer1_overflow) begin
        timer1_overflow_flag <= 1'b1;
      end else if (irq_ack && irq_req && req_src[`SRC_TIMER1]) begin
        timer1_overflow_flag <= 1'b0;
      end else if (wr_timer_irq_control) begin
        timer1_overflow_flag <= sfr_wdata[`BIT_TIMER1_OVERFLOW_FLAG];
      end
    end
  end

  // serial, bus and converter flags live in their own peripherals
  assign flags = {adc_high_limit_flag | adc_low_limit_flag,
                  i2c_request_flag,
                  uart_rx_flag | uart_tx_done_flag,
                  timer1_overflow_flag,
                  ext_request_flag[1],
                  timer0_overflow_flag,
                  ext_request_flag[0]};
  assign pending = flags & irq_enable[6:0] &
                   {7{irq_enable[`BIT_GLOBAL_IRQ_ENABLE]}};

  reg  [1:0] best_lvl;
  reg  [2:0] best_idx;
  reg        found;
  reg  [2:0] top;
  reg        allow;
  integer    i;

  always @* begin
    best_lvl = 2'd0;
    best_idx = 3'd0;
    found    = 1'b0;
    // ascending scan with strict compare keeps the earliest poll on ties
    for (i = 0; i < `NUM_SRC; i = i + 1) begin
      if (pending[i] && (!found ||
          level_of(priority_high_bits, priority_low_bits, i[2:0]) >
          best_lvl)) begin
        found    = 1'b1;
        best_lvl = level_of(priority_high_bits, priority_low_bits, i[2:0]);
        best_idx = i[2:0];
      end
    end
    top   = top_active(active_levels);
    // equal level never preempts, whatever its poll position
    allow = found && (!top[2] || ({1'b0, best_lvl} > {1'b0, top[1:0]}));
  end

  // request registered so vector and level stand steady for the core
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_req    <= 1'b0;
      irq_vector <= 8'h00;
      irq_level  <= 2'd0;
      req_src    <= 7'h00;
    end else if (irq_ack && irq_req) begin
      // drop for one cycle so stale state cannot be taken twice
      irq_req <= 1'b0;
      req_src <= 7'h00;
    end else begin
      irq_req <= allow;
      if (allow) begin
        irq_vector <= vector_of(best_idx);
        irq_level  <= best_lvl;
        req_src    <= 7'h01 << best_idx;
      end else begin
        req_src    <= 7'h00;
      end
    end
  end

  reg [3:0] next_active;

  always @* begin
    next_active = active_levels;
    if (return_from_irq) begin
      if (active_levels[3]) begin
        next_active[3] = 1'b0;
      end else if (active_levels[2]) begin
        next_active[2] = 1'b0;
      end else if (active_levels[1]) begin
        next_active[1] = 1'b0;
      end else begin
        next_active[0] = 1'b0;
      end
    end
    if (irq_ack && irq_req) begin
      next_active[irq_level] = 1'b1;
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      active_levels <= 4'h0;
    end else begin
      active_levels <= next_active;
    end
  end

endmodule // priority_interrupt_controller

`default_nettype wire

/* verif/irq_ctrl_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_sva (
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic       sfr_hit,
  input wire logic       irq_req,
  input wire logic [7:0] irq_vector,
  input wire logic [1:0] irq_level,
  input wire logic       irq_ack,
  input wire logic       return_from_irq,
  input wire logic [3:0] active_levels
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  // copies lag once more, since the request is registered after the write
  logic [7:0] ie_sh, lo_sh, hi_sh, ie_d, lo_d, hi_d;
  wire  [2:0] src = irq_vector[5:3];
  function automatic logic [3:0] top(input logic [3:0] a);
    top = a[3] ? 4'h8 : a[2] ? 4'h4 : {2'h0, a[1], a[0] & ~a[1]};
  endfunction
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      {ie_sh, lo_sh, hi_sh, ie_d, lo_d, hi_d} <= '0;
    end else begin
      {ie_d, lo_d, hi_d} <= {ie_sh, lo_sh, hi_sh};
      if (sfr_wr && sfr_addr == 8'hA8) ie_sh <= sfr_wdata;
      if (sfr_wr && sfr_addr == 8'hA9) lo_sh <= sfr_wdata;
      if (sfr_wr && sfr_addr == 8'hAA) hi_sh <= sfr_wdata;
    end
  end
  sequence ack_taken;
    irq_req && irq_ack;
  endsequence
  sequence ret_alone;
    return_from_irq && !(irq_req && irq_ack);
  endsequence
  AST_SFR_HIT: assert property (
    sfr_hit == (sfr_addr inside {8'h88, 8'hA8, 8'hA9, 8'hAA, 8'hAB}))
    else $error("decode flag wrong");
  AST_PRI7_ZERO: assert property (
    sfr_rd && (sfr_addr == 8'hA9 || sfr_addr == 8'hAA) |=> !sfr_rdata[7])
    else $error("priority bit 7 not zero");
  AST_ENABLE_GATE: assert property (
    irq_req |-> ie_d[7] && ie_d[src]) else $error("disabled source raised");
  AST_LEVEL_MAP: assert property (
    irq_req |-> irq_level == {hi_d[src], lo_d[src]})
    else $error("request level wrong");
  AST_VECTOR_MAP: assert property (
    irq_req |-> irq_vector[2:0] == 3'h3 && irq_vector[7:6] == 2'h0 &&
      src != 3'h7)
    else $error("vector off table");
  AST_NO_PREEMPT: assert property (
    irq_req |-> (active_levels >> irq_level) == 4'h0)
    else $error("request not above active level");
  AST_ACK_TAKEN: assert property (
    ack_taken |=> !irq_req && active_levels[$past(irq_level)])
    else $error("acknowledge not taken");
  AST_RETURN_TOP: assert property (
    ret_alone |=> active_levels ==
      ($past(active_levels) & ~top($past(active_levels))))
    else $error("return cleared wrong level");
endmodule // irq_ctrl_sva
bind priority_interrupt_controller irq_ctrl_sva irq_ctrl_sva_inst (
  .core_clk, .rstn, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata,
  .sfr_hit, .irq_req, .irq_vector, .irq_level, .irq_ack, .return_from_irq,
  .active_levels);
`default_nettype wire

/* verif/core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       irq_req,
  input  wire logic [7:0] irq_vector,
  input  wire logic [3:0] ack_delay,
  input  wire logic       ret_go,
  output var  logic       irq_ack,
  output var  logic       return_from_irq
);
  logic [3:0] wait_cnt;
  logic [7:0] sp;
  logic [7:0] last_vec;
  int         n_taken;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      {irq_ack, return_from_irq, wait_cnt, last_vec} <= '0;
      sp      <= 8'h07;
      n_taken <= 0;
    end else begin
      return_from_irq <= ret_go;
      sp <= sp + ((irq_ack && irq_req) ? 8'h02 : 8'h00)
               - (ret_go ? 8'h02 : 8'h00);
      wait_cnt <= (irq_req && !irq_ack) ? wait_cnt + 4'h1 : 4'h0;
      // slow answers come from ack_delay; a withdrawn request is not taken
      irq_ack <= irq_req && !irq_ack && wait_cnt >= ack_delay;
      if (irq_ack && irq_req) begin
        last_vec <= irq_vector;
        n_taken  <= n_taken + 1;
      end
    end
  end
endmodule // core_model
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       core_clk, rstn, sfr_wr, sfr_rd, ret_go, sfr_hit;
  logic       pin0, pin1, tov0, tov1, urx, utx, i2c, ahi, alo, run0, run1;
  logic       irq_req, irq_ack, return_from_irq;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, irq_vector, r, ie, lo, hi, e;
  logic [1:0] irq_level;
  logic [3:0] active_levels, ack_delay;
  integer     n_fail, checked, seed, i;
  priority_interrupt_controller priority_interrupt_controller_inst (
    .core_clk, .rstn, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata,
    .sfr_hit, .ext_request0_pin(pin0), .ext_request1_pin(pin1),
    .timer0_overflow(tov0), .timer1_overflow(tov1), .uart_rx_flag(urx),
    .uart_tx_done_flag(utx), .i2c_request_flag(i2c),
    .adc_high_limit_flag(ahi), .adc_low_limit_flag(alo), .timer0_run(run0),
    .timer1_run(run1), .irq_req, .irq_vector, .irq_level, .irq_ack,
    .return_from_irq, .active_levels);
  core_model core_model_inst (.core_clk, .rstn, .irq_req, .irq_vector,
    .ack_delay, .ret_go, .irq_ack, .return_from_irq);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk) {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
    @(negedge core_clk) sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge core_clk) {sfr_addr, sfr_rd} = {a, 1'b1};
    @(negedge core_clk) sfr_rd = 1'b0;
    chk(sfr_rdata, exp);
  endtask
  task automatic ret();
    @(negedge core_clk) ret_go = 1'b1;
    @(negedge core_clk) ret_go = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask
  // expect 00 when nothing may be taken within the bound
  task automatic wait_take(input logic [7:0] exp);
    int n0 = core_model_inst.n_taken;
    for (int t = 0; t < 40 && core_model_inst.n_taken == n0; t++)
      @(negedge core_clk);
    chk(core_model_inst.n_taken == n0 ? 8'h00 : core_model_inst.last_vec, exp);
  endtask
  function automatic logic [7:0] pick(input logic [6:0] q);
    logic [2:0] best;
    pick = 8'h00;
    best = 3'h0;
    for (int s = 6; s >= 0; s--)
      if (ie[7] && ie[s] && q[s] && {1'b0, hi[s], lo[s]} >= best) begin
        best = {1'b0, hi[s], lo[s]};
        pick = 8'(s * 8 + 3);
      end
  endfunction
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    #2500000;
    n_fail = n_fail + 1;
    tally_and_finish();
  end
  initial begin
    {rstn, sfr_wr, sfr_rd, ret_go, tov0, tov1, urx, utx, i2c, ahi, alo} = '0;
    {pin0, pin1, sfr_addr, sfr_wdata, ack_delay} = {2'h3, 20'h0};
    {n_fail, checked, seed} = {32'h0, 32'h0, 32'h10E5};
    repeat (8) @(posedge core_clk);
    @(negedge core_clk) rstn = 1'b1;
    rd(8'h88, 8'h00);
    rd(8'hA8, 8'h00);
    rd(8'hAB, 8'h05);
    rd(8'h90, 8'h00);
    wr(8'hA9, 8'hFF);
    rd(8'hA9, 8'h7F);
    wr(8'hAA, 8'hC3);
    rd(8'hAA, 8'h43);
    // edge mode first; a flag written with the mode change is lost
    wr(8'h88, 8'h05);
    wr(8'h88, 8'hFF);
    rd(8'h88, 8'hFF);
    chk({6'h0, run1, run0}, 8'h03);
    wr(8'h88, 8'h00);
    rd(8'h88, 8'h00);
    $display("register test done");
    for (i = 0; i < 30; i++) begin
      {r, lo, hi, ie} = $random(seed);
      ie[7] = (i % 5 != 0);
      ack_delay = 4'($random(seed));
      wr(8'hA8, 8'h00);
      wr(8'hA9, lo);
      wr(8'hAA, hi);
      // raised while disabled so every request counts as simultaneous
      @(negedge core_clk) {tov0, tov1, i2c} = {r[1], r[3], r[5]};
      {urx, utx} = {r[4] & r[0], r[4] & ~r[0]};
      {ahi, alo} = {r[6] & r[7], r[6] & ~r[7]};
      @(negedge core_clk) {tov0, tov1} = 2'h0;
      wr(8'hA8, ie);
      e = pick(r[6:0] & 7'h7A);
      wait_take(e);
      wr(8'hA8, 8'h00);
      {urx, utx, i2c, ahi, alo} = '0;
      wr(8'h88, 8'h00);
      if (e != 8'h00) ret();
      chk({4'h0, active_levels}, 8'h00);
    end
    $display("random priority test done");
    wr(8'hA9, 8'h70);
    wr(8'hAA, 8'h40);
    ack_delay = 4'h0;
    wr(8'hA8, 8'hF0);
    urx = 1'b1;
    wait_take(8'h23);
    i2c = 1'b1;
    wait_take(8'h00);
    ahi = 1'b1;
    wait_take(8'h33);
    chk({4'h0, active_levels}, 8'h0A);
    chk(core_model_inst.sp, 8'h0B);
    ahi = 1'b0;
    ret();
    chk({4'h0, active_levels}, 8'h02);
    urx = 1'b0;
    ret();
    wait_take(8'h2B);
    i2c = 1'b0;
    ret();
    $display("nesting test done");
    wr(8'hA8, 8'h00);
    wr(8'h88, 8'h05);
    pin0 = 1'b0;
    repeat (8) @(negedge core_clk);
    rd(8'h88, 8'h07);
    pin0 = 1'b1;
    // let the rising edge pass while only falling edges are enabled
    repeat (8) @(negedge core_clk);
    wr(8'h88, 8'h05);
    wr(8'hAB, 8'h02);
    pin0 = 1'b0;
    repeat (8) @(negedge core_clk);
    rd(8'h88, 8'h05);
    pin0 = 1'b1;
    repeat (8) @(negedge core_clk);
    rd(8'h88, 8'h07);
    wr(8'h88, 8'h00);
    pin1 = 1'b0;
    repeat (8) @(negedge core_clk);
    rd(8'h88, 8'h08);
    pin1 = 1'b1;
    repeat (8) @(negedge core_clk);
    rd(8'h88, 8'h00);
    wr(8'h88, 8'h01);
    wr(8'hAB, 8'h05);
    wr(8'hA8, 8'h81);
    pin0 = 1'b0;
    wait_take(8'h03);
    pin0 = 1'b1;
    rd(8'h88, 8'h01);
    ret();
    chk(core_model_inst.sp, 8'h07);
    $display("external pin test done");
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
